// ===== hdl/minor_fault_defs.vh
// Behaviour
// RULE_01 - A detected factor classed as a light alarm leaves the drive running, untripped, with a light-alarm indication.
// RULE_02 - The light-alarm signal is active whenever any light alarm is present.
// RULE_03 - A digital output terminal shows the light-alarm signal only when its function setting is 98.
// RULE_04 - The light-alarm selection is a 7-bit mask (0 to 127); a factor is a light alarm only where its bit is 1.
// RULE_05 - Mask bits 0..6 are overcycle, low current, wire break, feedback 1, feedback 2, loop 1 error, loop 2 error.
// RULE_06 - The overcycle factor rises once the slow-flow cycle count reaches its configured maximum.
// RULE_07 - The low-current factor rises when output current stays below its level for longer than its time.
// RULE_08 - A loop error factor rises when command minus feedback exceeds its level for longer than its timer.
// RULE_09 - Wire break and the two loop feedback warnings each raise their own factor.
// RULE_10 - With auto-reset on, a trip by an eligible factor is cleared automatically and operation restarts.
// RULE_11 - Trips are counted; once the count exceeds the retry number an alarm is issued and retries stop.
// RULE_12 - The retry number accepts 1 to 10, and 0 disables auto-reset.
// RULE_13 - Each auto-reset comes the reset interval (0.5 to 600.0 s) after entering the tripped state.
// RULE_14 - The retry counter clears after five minutes without any alarm.
// RULE_15 - The auto-reset selection is a 7-bit mask with the same bit layout; a 1 makes a factor eligible.
// RULE_16 - A detected factor whose light-alarm bit is 0 trips the drive and stops output.
`ifndef MINOR_FAULT_DEFS_VH
`define MINOR_FAULT_DEFS_VH

// Register byte offsets
`define RA_MINOR_SEL 8'h00
`define RA_RETRY_SEL 8'h04
`define RA_RETRY_LIMIT 8'h08
`define RA_RETRY_INTERVAL 8'h0c
`define RA_TERM_FIRST 8'h10
`define RA_TERM_LAST 8'h24
`define RA_UC_LEVEL 8'h28
`define RA_UC_TIME 8'h2c
`define RA_L1_LEVEL 8'h30
`define RA_L1_TIMER 8'h34
`define RA_L2_LEVEL 8'h38
`define RA_L2_TIMER 8'h3c
`define RA_OVERCYCLE 8'h40
`define RA_STATUS 8'h44
`define RA_IRQ_STATUS 8'h48
`define RA_IRQ_CLEAR 8'h4c
`define RA_IRQ_ENABLE 8'h50
`define RA_CONTROL 8'h54

// Factor bit positions
`define FB_OVERCYCLE 0
`define FB_LOW_CURRENT 1
`define FB_WIRE_BREAK 2
`define FB_FEEDBACK1 3
`define FB_FEEDBACK2 4
`define FB_LOOP1_ERR 5
`define FB_LOOP2_ERR 6

// Interrupt bit positions
`define IB_MINOR 0
`define IB_TRIP 1
`define IB_AUTO_RESET 2
`define IB_EXHAUSTED 3

// Reset values and limits
`define MASK_RESET 7'h00
`define LIMIT_RESET 4'h0
`define LIMIT_MAX 4'ha
`define INTERVAL_RESET 13'h0005
`define INTERVAL_MIN 13'h0005
`define INTERVAL_MAX 13'h1770
`define TERM_FUNC_MINOR 8'h62

// Timing: settings count in 0.1 s ticks
`define CLK_PERIOD_NS 100
`define TICK_PERIOD_NS 100000000
`define QUIET_TIME_S 300
`define QUIET_TICKS 12'hbb8

`endif

// ===== hdl/qualify_timer.v
`default_nettype none

// Raises its flag once a condition has held for more than a set number of ticks
module qualify_timer (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Condition and timing
  input wire tick,
  input wire cond,
  input wire [15:0] limit,
  // Qualified flag
  output reg flag
);

  reg [15:0] cnt;

  // Count only while the condition stands; any gap restarts the wait
  always @(posedge mclk) begin
    if (!rst_n) begin
      cnt <= 16'h0000;
      flag <= 1'b0;
    end else if (!cond) begin
      cnt <= 16'h0000;
      flag <= 1'b0;
    end else begin
      if (tick && cnt != 16'hffff) begin
        cnt <= cnt + 16'h0001;
      end
      flag <= (cnt > limit); // Strictly longer than the set time
    end
  end

endmodule // qualify_timer

`default_nettype wire

// ===== hdl/minor_fault_ctrl.v
// The register offsets and the APB slave port were decided locally.
`include "minor_fault_defs.vh"
`default_nettype none

module minor_fault_ctrl #(
  parameter TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input wire MCLK_I,
  input wire RST_N_I,
  // APB slave
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [7:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output reg [31:0] PRDATA_O,
  output reg PREADY_O,
  output reg PSLVERR_O,
  // Drive measurements and detector inputs
  input wire [15:0] OUT_CURRENT_I,
  input wire [15:0] LOOP1_CMD_I,
  input wire [15:0] LOOP1_FB_I,
  input wire [15:0] LOOP2_CMD_I,
  input wire [15:0] LOOP2_FB_I,
  input wire SLOW_FLOW_I,
  input wire CYCLE_DONE_I,
  input wire WIRE_BREAK_I,
  input wire FB1_WARN_I,
  input wire FB2_WARN_I,
  // Drive control
  output reg RUN_EN_O,
  output reg TRIP_O,
  output reg RESET_CMD_O,
  output reg RETRY_ALARM_O,
  // Light alarm and digital output terminals
  output reg MINOR_FAULT_O,
  output reg [5:0] DO_O,
  // Interrupt
  output reg IRQ_O
);

  localparam ST_RUN = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_HOLD = 2'b10;

  // Magnitude of command minus feedback
  function [15:0] abs_diff;
    input [15:0] a;
    input [15:0] b;
    begin
      abs_diff = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  // Software settings
  reg [6:0] minor_fault_select;
  reg [6:0] retry_factor_select;
  reg [3:0] retry_count_limit;
  reg [12:0] retry_interval;
  reg [7:0] term_func [0:5];
  reg [15:0] undercurrent_level;
  reg [15:0] undercurrent_time;
  reg [15:0] loop_one_error_level;
  reg [15:0] loop_one_error_timer;
  reg [15:0] loop_two_error_level;
  reg [15:0] loop_two_error_timer;
  reg [15:0] overcycle_setting_a;
  reg [3:0] irq_status;
  reg [3:0] irq_enable;

  // Block state
  reg [19:0] tick_cnt;
  reg tick;
  reg [15:0] cycle_cnt;
  reg overcycle;
  reg [1:0] state;
  reg tripped;
  reg exhausted;
  reg [4:0] trip_cnt;
  reg [12:0] ivl_cnt;
  reg [11:0] quiet_cnt;
  reg minor_prev;
  reg auto_reset_ev;
  reg exhaust_ev;
  reg trip_ev;
  reg [31:0] next_prdata;
  reg next_err;
  integer i;
  integer j;

  wire low_current;
  wire loop1_err;
  wire loop2_err;
  wire [6:0] factors;
  wire minor_now;
  wire [6:0] trip_cause;
  wire trip_req;
  wire eligible;
  wire [4:0] next_trip_cnt;
  wire acc;
  wire wr;
  wire [7:0] term_off;
  wire term_hit;
  wire [2:0] term_idx;
  wire manual_reset;
  wire [3:0] irq_event;

  // Slow APB slave: one wait state, so every access is two edges in access phase
  assign acc = PSEL_I & PENABLE_I & PREADY_O;
  assign wr = acc & PWRITE_I;
  assign term_off = PADDR_I - `RA_TERM_FIRST;
  assign term_hit = (PADDR_I >= `RA_TERM_FIRST) && (PADDR_I <= `RA_TERM_LAST) && (PADDR_I[1:0] == 2'b00);
  assign term_idx = term_off[4:2];
  assign manual_reset = wr && (PADDR_I == `RA_CONTROL) && PWDATA_I[0];

  // Timebase of 0.1 s, shared by every timed setting
  always @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      tick_cnt <= 20'h00000;
      tick <= 1'b0;
    end else if (tick_cnt == TICK_CYCLES[19:0] - 20'h00001) begin
      tick_cnt <= 20'h00000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 20'h00001;
      tick <= 1'b0;
    end
  end

  // Slow-flow cycle counter; the count restarts once flow is normal again
  always @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      cycle_cnt <= 16'h0000;
      overcycle <= 1'b0;
    end else if (!SLOW_FLOW_I) begin
      cycle_cnt <= 16'h0000;
      overcycle <= 1'b0;
    end else begin
      if (CYCLE_DONE_I && cycle_cnt != 16'hffff) begin
        cycle_cnt <= cycle_cnt + 16'h0001;
      end
      overcycle <= (overcycle_setting_a != 16'h0000) && (cycle_cnt >= overcycle_setting_a); // RULE_06
    end
  end

  // Qualified detectors
  qualify_timer u_low_current (
    .mclk(MCLK_I),
    .rst_n(RST_N_I),
    .tick(tick),
    .cond(OUT_CURRENT_I < undercurrent_level), // RULE_07
    .limit(undercurrent_time),
    .flag(low_current)
  );

  qualify_timer u_loop1_err (
    .mclk(MCLK_I),
    .rst_n(RST_N_I),
    .tick(tick),
    .cond(abs_diff(LOOP1_CMD_I, LOOP1_FB_I) > loop_one_error_level), // RULE_08
    .limit(loop_one_error_timer),
    .flag(loop1_err)
  );

  qualify_timer u_loop2_err (
    .mclk(MCLK_I),
    .rst_n(RST_N_I),
    .tick(tick),
    .cond(abs_diff(LOOP2_CMD_I, LOOP2_FB_I) > loop_two_error_level), // RULE_08
    .limit(loop_two_error_timer),
    .flag(loop2_err)
  );

  // Factor vector in mask order
  assign factors = {loop2_err, loop1_err, FB2_WARN_I, FB1_WARN_I, WIRE_BREAK_I, low_current, overcycle}; // RULE_05 RULE_09

  // Masked factors are light alarms, the rest trip
  assign minor_now = |(factors & minor_fault_select); // RULE_01 RULE_04
  assign trip_cause = factors & ~minor_fault_select; // RULE_16
  assign trip_req = (state == ST_RUN) && (trip_cause != 7'h00);
  assign eligible = ((trip_cause & ~retry_factor_select) == 7'h00); // RULE_15
  assign next_trip_cnt = trip_cnt + 5'h01;

  // Retry sequencer; a manual reset from software wins in any tripped state
  always @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      state <= ST_RUN;
      tripped <= 1'b0;
      exhausted <= 1'b0;
      trip_cnt <= 5'h00;
      ivl_cnt <= 13'h0000;
      quiet_cnt <= 12'h000;
      auto_reset_ev <= 1'b0;
      exhaust_ev <= 1'b0;
      trip_ev <= 1'b0;
    end else begin
      auto_reset_ev <= 1'b0;
      exhaust_ev <= 1'b0;
      trip_ev <= 1'b0;
      // Alarm-free time clears the retry counter
      if (state != ST_RUN || factors != 7'h00) begin
        quiet_cnt <= 12'h000;
      end else if (tick) begin
        if (quiet_cnt == `QUIET_TICKS - 12'h001) begin
          quiet_cnt <= 12'h000;
          trip_cnt <= 5'h00; // RULE_14
        end else begin
          quiet_cnt <= quiet_cnt + 12'h001;
        end
      end
      case (state)
        ST_RUN: begin
          if (trip_req) begin
            tripped <= 1'b1; // RULE_16
            trip_ev <= 1'b1;
            ivl_cnt <= 13'h0000;
            if (retry_count_limit == 4'h0 || !eligible) begin
              state <= ST_HOLD; // RULE_12
            end else if (next_trip_cnt <= {1'b0, retry_count_limit}) begin
              trip_cnt <= next_trip_cnt; // RULE_11
              state <= ST_WAIT; // RULE_10
            end else begin
              exhausted <= 1'b1; // RULE_11
              exhaust_ev <= 1'b1;
              state <= ST_HOLD;
            end
          end
        end
        ST_WAIT: begin
          if (manual_reset) begin
            tripped <= 1'b0;
            state <= ST_RUN;
          end else if (ivl_cnt >= retry_interval) begin
            tripped <= 1'b0; // RULE_13
            auto_reset_ev <= 1'b1; // RULE_10
            state <= ST_RUN;
          end else if (tick) begin
            ivl_cnt <= ivl_cnt + 13'h0001;
          end
        end
        ST_HOLD: begin
          if (manual_reset) begin
            tripped <= 1'b0;
            exhausted <= 1'b0;
            trip_cnt <= 5'h00;
            state <= ST_RUN;
          end
        end
        default: begin
          state <= ST_RUN;
          tripped <= 1'b0;
        end
      endcase
    end
  end

  // Registered drive and terminal outputs
  always @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      RUN_EN_O <= 1'b0;
      TRIP_O <= 1'b0;
      RESET_CMD_O <= 1'b0;
      RETRY_ALARM_O <= 1'b0;
      MINOR_FAULT_O <= 1'b0;
      DO_O <= 6'h00;
      minor_prev <= 1'b0;
    end else begin
      RUN_EN_O <= !tripped; // RULE_01
      TRIP_O <= tripped;
      RESET_CMD_O <= auto_reset_ev;
      RETRY_ALARM_O <= exhausted;
      MINOR_FAULT_O <= minor_now; // RULE_02
      minor_prev <= minor_now;
      for (i = 0; i < 6; i = i + 1) begin
        DO_O[i] <= (term_func[i] == `TERM_FUNC_MINOR) && minor_now; // RULE_03
      end
    end
  end

  // Sticky interrupt status; a new event beats a clear in the same cycle
  assign irq_event = {exhaust_ev, auto_reset_ev, trip_ev, minor_now & ~minor_prev};
  always @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      irq_status <= 4'h0;
      IRQ_O <= 1'b0;
    end else begin
      if (wr && PADDR_I == `RA_IRQ_CLEAR) begin
        irq_status <= (irq_status & ~PWDATA_I[3:0]) | irq_event;
      end else begin
        irq_status <= irq_status | irq_event;
      end
      IRQ_O <= |(irq_status & irq_enable);
    end
  end

  // Register writes; out-of-range retry settings are clamped
  always @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      minor_fault_select <= `MASK_RESET;
      retry_factor_select <= `MASK_RESET;
      retry_count_limit <= `LIMIT_RESET;
      retry_interval <= `INTERVAL_RESET;
      undercurrent_level <= 16'h0000;
      undercurrent_time <= 16'h0000;
      loop_one_error_level <= 16'hffff;
      loop_one_error_timer <= 16'h0000;
      loop_two_error_level <= 16'hffff;
      loop_two_error_timer <= 16'h0000;
      overcycle_setting_a <= 16'h0000;
      irq_enable <= 4'h0;
      for (j = 0; j < 6; j = j + 1) begin
        term_func[j] <= 8'h00;
      end
    end else if (wr) begin
      case (PADDR_I)
        `RA_MINOR_SEL: minor_fault_select <= PWDATA_I[6:0]; // RULE_04
        `RA_RETRY_SEL: retry_factor_select <= PWDATA_I[6:0]; // RULE_15
        `RA_RETRY_LIMIT: begin
          retry_count_limit <= (PWDATA_I[31:0] > {28'h0000000, `LIMIT_MAX}) ? `LIMIT_MAX : PWDATA_I[3:0]; // RULE_12
        end
        `RA_RETRY_INTERVAL: begin
          if (PWDATA_I[31:0] < {19'h00000, `INTERVAL_MIN}) begin
            retry_interval <= `INTERVAL_MIN; // RULE_13
          end else if (PWDATA_I[31:0] > {19'h00000, `INTERVAL_MAX}) begin
            retry_interval <= `INTERVAL_MAX;
          end else begin
            retry_interval <= PWDATA_I[12:0];
          end
        end
        `RA_UC_LEVEL: undercurrent_level <= PWDATA_I[15:0];
        `RA_UC_TIME: undercurrent_time <= PWDATA_I[15:0];
        `RA_L1_LEVEL: loop_one_error_level <= PWDATA_I[15:0];
        `RA_L1_TIMER: loop_one_error_timer <= PWDATA_I[15:0];
        `RA_L2_LEVEL: loop_two_error_level <= PWDATA_I[15:0];
        `RA_L2_TIMER: loop_two_error_timer <= PWDATA_I[15:0];
        `RA_OVERCYCLE: overcycle_setting_a <= PWDATA_I[15:0];
        `RA_IRQ_ENABLE: irq_enable <= PWDATA_I[3:0];
        default: begin
          if (term_hit) begin
            term_func[term_idx] <= PWDATA_I[7:0];
          end
        end
      endcase
    end
  end

  // Read mux and unmapped-address error
  always @* begin
    next_prdata = 32'h00000000;
    next_err = 1'b0;
    case (PADDR_I)
      `RA_MINOR_SEL: next_prdata[6:0] = minor_fault_select;
      `RA_RETRY_SEL: next_prdata[6:0] = retry_factor_select;
      `RA_RETRY_LIMIT: next_prdata[3:0] = retry_count_limit;
      `RA_RETRY_INTERVAL: next_prdata[12:0] = retry_interval;
      `RA_UC_LEVEL: next_prdata[15:0] = undercurrent_level;
      `RA_UC_TIME: next_prdata[15:0] = undercurrent_time;
      `RA_L1_LEVEL: next_prdata[15:0] = loop_one_error_level;
      `RA_L1_TIMER: next_prdata[15:0] = loop_one_error_timer;
      `RA_L2_LEVEL: next_prdata[15:0] = loop_two_error_level;
      `RA_L2_TIMER: next_prdata[15:0] = loop_two_error_timer;
      `RA_OVERCYCLE: next_prdata[15:0] = overcycle_setting_a;
      `RA_STATUS: next_prdata = {16'h0000, trip_cnt[3:0], 1'b0, exhausted, tripped, minor_now, 1'b0, factors};
      `RA_IRQ_STATUS: next_prdata[3:0] = irq_status;
      `RA_IRQ_CLEAR: next_prdata = 32'h00000000;
      `RA_IRQ_ENABLE: next_prdata[3:0] = irq_enable;
      `RA_CONTROL: next_prdata = 32'h00000000;
      default: begin
        if (term_hit) begin
          next_prdata[7:0] = term_func[term_idx];
        end else begin
          next_err = 1'b1;
        end
      end
    endcase
  end

  // Ready rises on the first access-phase edge and drops after the taken edge
  always @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      PREADY_O <= 1'b0;
      PRDATA_O <= 32'h00000000;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= PSEL_I & PENABLE_I & ~PREADY_O;
      if (PSEL_I & PENABLE_I & ~PREADY_O) begin
        PRDATA_O <= PWRITE_I ? 32'h00000000 : next_prdata;
        PSLVERR_O <= next_err;
      end else begin
        PSLVERR_O <= 1'b0;
      end
    end
  end

endmodule // minor_fault_ctrl

`default_nettype wire

// ===== verification/minor_fault_assertions.sv
`default_nettype none

module minor_fault_checker #(
  parameter TICK_CYCLES = 10
) (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // Drive control and alarm outputs
  input wire logic RUN_EN_O,
  input wire logic TRIP_O,
  input wire logic RESET_CMD_O,
  input wire logic RETRY_ALARM_O,
  input wire logic MINOR_FAULT_O,
  input wire logic [5:0] DO_O
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] held;

  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_N_I);

  // Cycles spent tripped, so the retry spacing can be judged
  always @(posedge MCLK_I) begin
    if (!RST_N_I || !TRIP_O) held <= 32'h0;
    else held <= held + 32'h1;
  end

  trip_stops_run_a: assert property (TRIP_O |-> !RUN_EN_O)
    else $error("output running while tripped");
  light_keeps_run_a: assert property ($rose(MINOR_FAULT_O) |-> RUN_EN_O)
    else $error("light alarm stopped the drive");
  terminal_needs_light_a: assert property (|DO_O |-> MINOR_FAULT_O || $past(MINOR_FAULT_O))
    else $error("terminal active without light alarm");
  reset_cmd_pulse_a: assert property (RESET_CMD_O |=> !RESET_CMD_O)
    else $error("reset command wider than one cycle");
  reset_clears_trip_a: assert property (RESET_CMD_O |-> ##[0:1] !TRIP_O)
    else $error("trip not cleared by reset command");
  reset_after_trip_a: assert property ($rose(RESET_CMD_O) |-> $past(TRIP_O))
    else $error("reset command without trip");
  alarm_blocks_reset_a: assert property (RETRY_ALARM_O |-> !RESET_CMD_O)
    else $error("reset command after retries exhausted");
  alarm_holds_trip_a: assert property ($rose(RETRY_ALARM_O) |-> TRIP_O)
    else $error("retry alarm without trip");
  reset_spacing_a: assert property ($rose(RESET_CMD_O) |->
    (held >= 4 * TICK_CYCLES) || ($past(held) >= 4 * TICK_CYCLES))
    else $error("reset command before interval");
endmodule // minor_fault_checker

`default_nettype wire

// ===== verification/do_watcher.sv
`default_nettype none

module do_watcher (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Watched terminal
  input wire logic line_i,
  // Alarm onsets seen
  output logic [7:0] rises_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last;

  // Peripheral reacts to onsets only; a held level is one event
  always @(posedge clk_i) begin
    last <= line_i;
    if (!rst_n_i) rises_o <= 8'h00;
    else if (line_i && !last) rises_o <= rises_o + 8'h01;
  end
endmodule // do_watcher

`default_nettype wire

// ===== verification/light_alarm_and_auto_reset_test.sv
`default_nettype none

module light_alarm_and_auto_reset_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic MCLK_I = 1'b0, RST_N_I = 1'b0, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
  logic [7:0] PADDR_I = 8'h00;
  logic [31:0] PWDATA_I = 32'h0, PRDATA_O, rdat;
  logic PREADY_O, PSLVERR_O, rerr;
  logic [15:0] OUT_CURRENT_I = 16'h1000, LOOP1_CMD_I = 16'h0100, LOOP1_FB_I = 16'h0100;
  logic [15:0] LOOP2_CMD_I = 16'h0100, LOOP2_FB_I = 16'h0100;
  logic SLOW_FLOW_I = 1'b0, CYCLE_DONE_I = 1'b0, WIRE_BREAK_I = 1'b0, FB1_WARN_I = 1'b0, FB2_WARN_I = 1'b0;
  logic RUN_EN_O, TRIP_O, RESET_CMD_O, RETRY_ALARM_O, MINOR_FAULT_O, IRQ_O;
  logic [5:0] DO_O;
  logic [7:0] rises;
  int miscompares = 0, compares = 0, cycles = 0, n;

  minor_fault_ctrl #(.TICK_CYCLES(10)) u_minor_fault_ctrl (
    .MCLK_I(MCLK_I), .RST_N_I(RST_N_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .OUT_CURRENT_I(OUT_CURRENT_I), .LOOP1_CMD_I(LOOP1_CMD_I), .LOOP1_FB_I(LOOP1_FB_I),
    .LOOP2_CMD_I(LOOP2_CMD_I), .LOOP2_FB_I(LOOP2_FB_I),
    .SLOW_FLOW_I(SLOW_FLOW_I), .CYCLE_DONE_I(CYCLE_DONE_I), .WIRE_BREAK_I(WIRE_BREAK_I),
    .FB1_WARN_I(FB1_WARN_I), .FB2_WARN_I(FB2_WARN_I),
    .RUN_EN_O(RUN_EN_O), .TRIP_O(TRIP_O), .RESET_CMD_O(RESET_CMD_O), .RETRY_ALARM_O(RETRY_ALARM_O),
    .MINOR_FAULT_O(MINOR_FAULT_O), .DO_O(DO_O), .IRQ_O(IRQ_O)
  );
  do_watcher u_do_watcher (.clk_i(MCLK_I), .rst_n_i(RST_N_I), .line_i(DO_O[0]), .rises_o(rises));

  // Clock and hang guard
  always #50 MCLK_I = ~MCLK_I;
  always @(posedge MCLK_I) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      close_out;
    end
  end

  task close_out;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; trailing edge keeps back-to-back calls off one time step
  // No wait limit here: a lost answer is ended by the hang guard
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL_I <= 1'b1;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge MCLK_I);
    PENABLE_I <= 1'b1;
    do begin
      @(posedge MCLK_I);
    end while (PREADY_O !== 1'b1);
    rdat = PRDATA_O;
    rerr = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
    @(posedge MCLK_I);
  endtask

  function logic pick(input int s);
    case (s)
      0: pick = MINOR_FAULT_O;
      1: pick = TRIP_O;
      default: pick = RESET_CMD_O;
    endcase
  endfunction

  // Bounded wait for an output level; n holds the cycles spent
  task await(input int s, input logic v, input int lim);
    n = 0;
    while (pick(s) !== v && n < lim) begin
      @(posedge MCLK_I);
      n++;
    end
  endtask

  // Create the condition behind one factor bit
  task raise(input int b);
    case (b)
      0: begin
        SLOW_FLOW_I <= 1'b1;
        repeat (3) begin
          @(posedge MCLK_I) CYCLE_DONE_I <= 1'b1;
          @(posedge MCLK_I) CYCLE_DONE_I <= 1'b0;
        end
      end
      1: OUT_CURRENT_I <= 16'h0000;
      2: WIRE_BREAK_I <= 1'b1;
      3: FB1_WARN_I <= 1'b1;
      4: FB2_WARN_I <= 1'b1;
      5: LOOP1_CMD_I <= 16'h0200;
      default: LOOP2_CMD_I <= 16'h0200;
    endcase
  endtask

  task drop;
    SLOW_FLOW_I <= 1'b0;
    OUT_CURRENT_I <= 16'h1000;
    {WIRE_BREAK_I, FB1_WARN_I, FB2_WARN_I} <= 3'h0;
    LOOP1_CMD_I <= 16'h0100;
    LOOP2_CMD_I <= 16'h0100;
  endtask

  task regs;
    apb(1'b0, 8'h00, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rdat, 32'h5);
    apb(1'b1, 8'h00, 32'hff);
    apb(1'b0, 8'h00, 32'h0);
    chk(rdat, 32'h7f);
    apb(1'b1, 8'h08, 32'hf);
    apb(1'b0, 8'h08, 32'h0);
    chk(rdat, 32'ha);
    apb(1'b0, 8'h58, 32'h0);
    chk(rerr, 1'b1);
    chk(rdat, 32'h0);
    // Short timed settings; terminal 1 gets a neighbouring function code
    apb(1'b1, 8'h28, 32'h100);
    apb(1'b1, 8'h2c, 32'h2);
    apb(1'b1, 8'h30, 32'h10);
    apb(1'b1, 8'h34, 32'h2);
    apb(1'b1, 8'h38, 32'h10);
    apb(1'b1, 8'h3c, 32'h2);
    apb(1'b1, 8'h40, 32'h3);
    apb(1'b1, 8'h10, 32'h62);
    apb(1'b1, 8'h14, 32'h61);
  endtask

  task light_scan;
    apb(1'b1, 8'h50, 32'h1);
    for (int b = 0; b < 7; b++) begin
      raise(b);
      await(0, 1'b1, 400);
      chk(MINOR_FAULT_O, 1'b1);
      apb(1'b0, 8'h44, 32'h0);
      chk(rdat[6:0], 7'h01 << b);
      chk({RUN_EN_O, TRIP_O, DO_O, IRQ_O}, 9'h103);
      apb(1'b1, 8'h4c, 32'h1);
      repeat (2) @(posedge MCLK_I);
      chk(IRQ_O, 1'b0);
      drop;
      await(0, 1'b0, 400);
      chk(MINOR_FAULT_O, 1'b0);
    end
    // Masked interrupt stays quiet; watcher saw every onset
    apb(1'b1, 8'h50, 32'h0);
    raise(2);
    await(0, 1'b1, 50);
    repeat (2) @(posedge MCLK_I);
    chk({IRQ_O, DO_O}, 7'h01);
    drop;
    await(0, 1'b0, 50);
    chk(rises, 8'h08);
  endtask

  task retry_run;
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h04, 32'h4);
    apb(1'b1, 8'h08, 32'h2);
    raise(2);
    await(1, 1'b1, 10);
    chk({RUN_EN_O, TRIP_O, MINOR_FAULT_O}, 3'b010);
    for (int i = 0; i < 2; i++) begin
      await(2, 1'b1, 200);
      chk(n >= 38 && n <= 56, 1'b1);
      await(1, 1'b1, 10);
      chk(TRIP_O, 1'b1);
    end
    await(2, 1'b1, 200);
    chk({n == 200, RETRY_ALARM_O}, 2'b11);
    // Trip, auto reset and exhaustion all latched, light alarm left from the scan
    apb(1'b0, 8'h48, 32'h0);
    chk(rdat, 32'hf);
    drop;
    apb(1'b1, 8'h54, 32'h1);
    repeat (2) @(posedge MCLK_I);
    chk({TRIP_O, RETRY_ALARM_O}, 2'b00);
  endtask

  // Retries off, then a cause outside the retry selection
  task refuse;
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, 8'h08, i ? 32'h2 : 32'h0);
      apb(1'b1, 8'h04, i ? 32'h7b : 32'h4);
      raise(2);
      await(1, 1'b1, 10);
      drop;
      await(2, 1'b1, 200);
      chk({n == 200, RETRY_ALARM_O, TRIP_O}, 3'b101);
      apb(1'b1, 8'h54, 32'h1);
    end
  endtask

  task quiet;
    apb(1'b1, 8'h04, 32'h4);
    apb(1'b1, 8'h08, 32'h1);
    raise(2);
    await(1, 1'b1, 10);
    drop;
    await(2, 1'b1, 200);
    apb(1'b0, 8'h44, 32'h0);
    chk(rdat[15:12], 4'h1);
    repeat (29000) @(posedge MCLK_I);
    apb(1'b0, 8'h44, 32'h0);
    chk(rdat[15:12], 4'h1);
    repeat (1200) @(posedge MCLK_I);
    apb(1'b0, 8'h44, 32'h0);
    chk(rdat[15:12], 4'h0);
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge MCLK_I);
    RST_N_I <= 1'b1;
    @(posedge MCLK_I);
    regs;
    light_scan;
    retry_run;
    refuse;
    quiet;
    close_out;
  end
endmodule // light_alarm_and_auto_reset_test

bind minor_fault_ctrl minor_fault_checker #(.TICK_CYCLES(TICK_CYCLES)) u_minor_fault_checker (
  .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .RUN_EN_O(RUN_EN_O), .TRIP_O(TRIP_O), .RESET_CMD_O(RESET_CMD_O),
  .RETRY_ALARM_O(RETRY_ALARM_O), .MINOR_FAULT_O(MINOR_FAULT_O), .DO_O(DO_O)
);

`default_nettype wire
